/* core/metering_regs_consts.svh */
// named offsets, widths and reset values of the metering register slice
`ifndef METERING_REGS_CONSTS_SVH
`define METERING_REGS_CONSTS_SVH

// bus geometry: register index is byte address divided by four
`define BUS_ADR_W 18
`define BUS_DAT_W 32
`define BUS_SEL_W 4
`define IDX_W 16
`define IDX_LSB 2
`define HALF_W 16
`define LANE_W 8
`define HALF_LANES 2
`define RMS_W 24
`define TRIM_W 10
`define RMS_PAD 8'h00

// register indices
`define IDX_C_FUND_I_RMS 16'he53b
`define IDX_C_FUND_V_RMS 16'he53c
`define IDX_RSVD_LO_FIRST 16'he53d
`define IDX_RSVD_LO_LAST 16'he5fe
`define IDX_CAPTURE 16'he5ff
`define IDX_PEAK_PHASE 16'he600
`define IDX_DELAY_0 16'he601
`define IDX_DELAY_1 16'he602
`define IDX_DELAY_2 16'he603
`define IDX_IDLE_LOAD 16'he608
`define IDX_LINE_CYCLE 16'he60c
`define IDX_CROSS_TOUT 16'he60d
`define IDX_CALC_MODE 16'he60e
`define IDX_PULSE_CFG 16'he610
`define IDX_PULSE1_DIV 16'he611
`define IDX_PULSE2_DIV 16'he612
`define IDX_PULSE3_DIV 16'he613
`define IDX_A_TRIM 16'he614
`define IDX_B_TRIM 16'he615
`define IDX_C_TRIM 16'he616
`define IDX_POWER_SIGN 16'he617
`define IDX_MAIN_CFG 16'he618
`define IDX_RSVD_HI_FIRST 16'he619
`define IDX_RSVD_HI_LAST 16'he6ff

// reset values
`define RST_LINE_CYCLE 16'hffff
`define RST_CROSS_TOUT 16'hffff
`define RST_CALC_MODE 16'h01ff
`define RST_PULSE_CFG 16'h0e88
`define RST_DIVISOR 16'h0000
`define RST_TRIM 16'h0000
`define RST_MAIN_CFG 16'h0010
`define RST_WORD32 32'h00000000

// number of software-writable registers
`define RW_COUNT 11

`endif

/* core/metering_regs_pkg.sv */
// types shared by the metering register slice
package metering_regs_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_e;

	typedef struct packed {
		bus_state_e state;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] capture;
	} slave_state_s;

	typedef struct packed {
		logic [15:0] value;
	} cell_state_s;

endpackage

/* core/config_word_cell.sv */
// one writable configuration word with 8-bit lane enables and a width mask
`timescale 1ns/1ns
`include "metering_regs_consts.svh"

module config_word_cell
	import metering_regs_pkg::*;
#(
	parameter int WIDTH = `HALF_W,
	parameter logic [15:0] RESET_VAL = 16'h0000
)
(
	// clock and synchronised reset
	input wire logic core_clk,
	input wire logic rst_sync_n,
	// write port
	input wire logic wr_en,
	input wire logic [`HALF_LANES-1:0] wr_sel,
	input wire logic [`HALF_W-1:0] wr_data,
	// stored word, zero above WIDTH
	output logic [`HALF_W-1:0] value
);
	import metering_regs_pkg::*;

	localparam logic [31:0] MASK32 = (32'h1 << WIDTH) - 32'h1;
	localparam logic [15:0] MASK = MASK32[15:0];
	localparam cell_state_s CELL_RESET = '{value: RESET_VAL & MASK};

	cell_state_s cell_reg;
	cell_state_s cell_next;

	always_comb
	begin
		cell_next = cell_reg;
		if (wr_en)
		begin
			for (int l = 0; l < `HALF_LANES; l++)
			begin
				if (wr_sel[l])
					cell_next.value[l*`LANE_W +: `LANE_W] = wr_data[l*`LANE_W +: `LANE_W];
			end
		end
		// bits above the field width never store
		cell_next.value = cell_next.value & MASK;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			cell_reg <= CELL_RESET;
		else
			cell_reg <= cell_next;
	end

	assign value = cell_reg.value;

endmodule // config_word_cell

/* core/metering_config_status_regs.sv */
// wishbone register slice: phase c rms, transfer capture, status and configuration words
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "metering_regs_consts.svh"

module metering_config_status_regs
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`BUS_ADR_W-1:0] wb_adr_i,
	input wire logic [`BUS_SEL_W-1:0] wb_sel_i,
	input wire logic [`BUS_DAT_W-1:0] wb_dat_i,
	output logic [`BUS_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// measurement results from the metering core
	input wire logic [`RMS_W-1:0] phase_c_fund_current_rms,
	input wire logic [`RMS_W-1:0] phase_c_fund_voltage_rms,
	input wire logic [`HALF_W-1:0] peak_phase_status,
	input wire logic [`HALF_W-1:0] phase_delay_0,
	input wire logic [`HALF_W-1:0] phase_delay_1,
	input wire logic [`HALF_W-1:0] phase_delay_2,
	input wire logic [`HALF_W-1:0] idle_load_status,
	input wire logic [`HALF_W-1:0] power_sign_status,
	// configuration to the metering core
	output logic [`HALF_W-1:0] line_cycle_count,
	output logic [`HALF_W-1:0] crossing_timeout_count,
	output logic [`HALF_W-1:0] calc_mode_control,
	output logic [`HALF_W-1:0] pulse_output_config,
	output logic [`HALF_W-1:0] pulse1_divisor,
	output logic [`HALF_W-1:0] pulse2_divisor,
	output logic [`HALF_W-1:0] pulse3_divisor,
	output logic [`TRIM_W-1:0] phase_a_phase_trim,
	output logic [`TRIM_W-1:0] phase_b_phase_trim,
	output logic [`TRIM_W-1:0] phase_c_phase_trim,
	output logic [`HALF_W-1:0] main_config,
	// last completed read of a 32-bit rms word, also readable on the bus
	output logic [`BUS_DAT_W-1:0] last_word_transfer_capture
);
	import metering_regs_pkg::*;

	localparam slave_state_s SLAVE_RESET = '{
		state: BUS_IDLE,
		ack: 1'b0,
		rdata: `RST_WORD32,
		capture: `RST_WORD32
	};

	// index, reset value and width of each writable word, in generate order
	localparam logic [`IDX_W-1:0] RW_IDX [`RW_COUNT] = '{
		`IDX_LINE_CYCLE, `IDX_CROSS_TOUT, `IDX_CALC_MODE, `IDX_PULSE_CFG,
		`IDX_PULSE1_DIV, `IDX_PULSE2_DIV, `IDX_PULSE3_DIV,
		`IDX_A_TRIM, `IDX_B_TRIM, `IDX_C_TRIM, `IDX_MAIN_CFG
	};
	localparam logic [`HALF_W-1:0] RW_RST [`RW_COUNT] = '{
		`RST_LINE_CYCLE, `RST_CROSS_TOUT, `RST_CALC_MODE, `RST_PULSE_CFG,
		`RST_DIVISOR, `RST_DIVISOR, `RST_DIVISOR,
		`RST_TRIM, `RST_TRIM, `RST_TRIM, `RST_MAIN_CFG
	};
	localparam int RW_WID [`RW_COUNT] = '{
		`HALF_W, `HALF_W, `HALF_W, `HALF_W, `HALF_W, `HALF_W, `HALF_W,
		`TRIM_W, `TRIM_W, `TRIM_W, `HALF_W
	};

	logic [1:0] rst_pipe;
	logic rst_sync_n;
	slave_state_s slave_reg;
	slave_state_s slave_next;
	logic [`IDX_W-1:0] word_idx;
	logic bus_req;
	logic wr_commit;
	logic [`BUS_DAT_W-1:0] read_word;
	logic is_word32;
	logic [`HALF_W-1:0] rw_value [`RW_COUNT];

	// reset release through two flip-flops
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	assign word_idx = wb_adr_i[`BUS_ADR_W-1:`IDX_LSB];
	assign bus_req = wb_cyc_i && wb_stb_i;
	// writes land at the edge where the master sees ack
	assign wr_commit = slave_reg.ack && bus_req && wb_we_i;
	assign is_word32 = (word_idx == `IDX_C_FUND_I_RMS) || (word_idx == `IDX_C_FUND_V_RMS);

	// writable words; any index not in the table, read-only or reserved, stores nothing
	genvar g;
	generate
		for (g = 0; g < `RW_COUNT; g++)
		begin : g_rw
			config_word_cell #(
				.WIDTH(RW_WID[g]),
				.RESET_VAL(RW_RST[g])
			) u_cell (
				.core_clk(core_clk),
				.rst_sync_n(rst_sync_n),
				.wr_en(wr_commit && (word_idx == RW_IDX[g])),
				.wr_sel(wb_sel_i[`HALF_LANES-1:0]),
				.wr_data(wb_dat_i[`HALF_W-1:0]),
				.value(rw_value[g])
			);
		end
	endgenerate

	assign line_cycle_count = rw_value[0];
	assign crossing_timeout_count = rw_value[1];
	assign calc_mode_control = rw_value[2];
	assign pulse_output_config = rw_value[3];
	assign pulse1_divisor = rw_value[4];
	assign pulse2_divisor = rw_value[5];
	assign pulse3_divisor = rw_value[6];
	assign phase_a_phase_trim = rw_value[7][`TRIM_W-1:0];
	assign phase_b_phase_trim = rw_value[8][`TRIM_W-1:0];
	assign phase_c_phase_trim = rw_value[9][`TRIM_W-1:0];
	assign main_config = rw_value[10];

	// read mux; narrow words sit in the low bits, unmapped and reserved read zero
	always_comb
	begin
		read_word = `RST_WORD32;
		case (word_idx)
			`IDX_C_FUND_I_RMS: read_word = {`RMS_PAD, phase_c_fund_current_rms};
			`IDX_C_FUND_V_RMS: read_word = {`RMS_PAD, phase_c_fund_voltage_rms};
			`IDX_CAPTURE: read_word = slave_reg.capture;
			`IDX_PEAK_PHASE: read_word[`HALF_W-1:0] = peak_phase_status;
			`IDX_DELAY_0: read_word[`HALF_W-1:0] = phase_delay_0;
			`IDX_DELAY_1: read_word[`HALF_W-1:0] = phase_delay_1;
			`IDX_DELAY_2: read_word[`HALF_W-1:0] = phase_delay_2;
			`IDX_IDLE_LOAD: read_word[`HALF_W-1:0] = idle_load_status;
			`IDX_POWER_SIGN: read_word[`HALF_W-1:0] = power_sign_status;
			`IDX_LINE_CYCLE: read_word[`HALF_W-1:0] = rw_value[0];
			`IDX_CROSS_TOUT: read_word[`HALF_W-1:0] = rw_value[1];
			`IDX_CALC_MODE: read_word[`HALF_W-1:0] = rw_value[2];
			`IDX_PULSE_CFG: read_word[`HALF_W-1:0] = rw_value[3];
			`IDX_PULSE1_DIV: read_word[`HALF_W-1:0] = rw_value[4];
			`IDX_PULSE2_DIV: read_word[`HALF_W-1:0] = rw_value[5];
			`IDX_PULSE3_DIV: read_word[`HALF_W-1:0] = rw_value[6];
			`IDX_A_TRIM: read_word[`HALF_W-1:0] = rw_value[7];
			`IDX_B_TRIM: read_word[`HALF_W-1:0] = rw_value[8];
			`IDX_C_TRIM: read_word[`HALF_W-1:0] = rw_value[9];
			`IDX_MAIN_CFG: read_word[`HALF_W-1:0] = rw_value[10];
			default: read_word = `RST_WORD32;
		endcase
	end

	// bus sequencer: sample at request, answer one cycle later, then one idle cycle
	always_comb
	begin
		slave_next = slave_reg;
		slave_next.ack = 1'b0;
		case (slave_reg.state)
			BUS_IDLE:
			begin
				if (bus_req)
				begin
					slave_next.state = BUS_ACK;
					slave_next.ack = 1'b1;
					slave_next.rdata = wb_we_i ? `RST_WORD32 : read_word;
				end
			end
			BUS_ACK:
			begin
				slave_next.state = BUS_IDLE;
				// a completed read of a 32-bit word is kept; writes there are refused
				if (bus_req && !wb_we_i && is_word32)
					slave_next.capture = slave_reg.rdata;
			end
			default:
			begin
				slave_next.state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			slave_reg <= SLAVE_RESET;
		else
			slave_reg <= slave_next;
	end

	assign wb_ack_o = slave_reg.ack;
	assign wb_dat_o = slave_reg.rdata;
	assign last_word_transfer_capture = slave_reg.capture;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_sync_n);

	property p_capture_follows_read;
		(wb_ack_o && bus_req && !wb_we_i && word_idx == `IDX_C_FUND_V_RMS)
			|=> (last_word_transfer_capture == $past(wb_dat_o));
	endproperty
	a_capture_follows_read: assert property (p_capture_follows_read)
		else $error("capture missed the last 32-bit read");

	property p_current_rms_padded;
		(wb_ack_o && !wb_we_i && word_idx == `IDX_C_FUND_I_RMS)
			|-> (wb_dat_o == {`RMS_PAD, $past(phase_c_fund_current_rms)});
	endproperty
	a_current_rms_padded: assert property (p_current_rms_padded)
		else $error("current rms read wrong or not zero padded");

	property p_trim_narrow;
		(wr_commit && word_idx == `IDX_B_TRIM && wb_sel_i[1:0] == 2'b11)
			|=> (phase_b_phase_trim == $past(wb_dat_i[`TRIM_W-1:0])) ##1
			(!wb_ack_o || wb_dat_o[`BUS_DAT_W-1:`TRIM_W] == 22'h000000);
	endproperty
	a_trim_narrow: assert property (p_trim_narrow)
		else $error("trim word did not store ten bits");

	property p_line_cycle_write;
		(wr_commit && word_idx == `IDX_LINE_CYCLE && wb_sel_i[1:0] == 2'b11)
			|=> (line_cycle_count == $past(wb_dat_i[`HALF_W-1:0]));
	endproperty
	a_line_cycle_write: assert property (p_line_cycle_write)
		else $error("line cycle count write lost");

	property p_reset_values;
		$rose(rst_sync_n) |-> (line_cycle_count == `RST_LINE_CYCLE)
			&& (calc_mode_control == `RST_CALC_MODE)
			&& (pulse_output_config == `RST_PULSE_CFG)
			&& (main_config == `RST_MAIN_CFG)
			&& (phase_a_phase_trim == 10'h000);
	endproperty
	a_reset_values: assert property (@(posedge core_clk) disable iff (!rst_n) p_reset_values)
		else $error("configuration reset value wrong");

	property p_delay_read;
		(wb_ack_o && !wb_we_i && word_idx == `IDX_DELAY_1)
			|-> (wb_dat_o == {16'h0000, $past(phase_delay_1)});
	endproperty
	a_delay_read: assert property (p_delay_read)
		else $error("phase delay read wrong");

	property p_sign_read;
		(wb_ack_o && !wb_we_i && word_idx == `IDX_POWER_SIGN)
			|-> (wb_dat_o[`HALF_W-1:0] == $past(power_sign_status));
	endproperty
	a_sign_read: assert property (p_sign_read)
		else $error("power sign read wrong");

	property p_idle_read;
		(wb_ack_o && !wb_we_i && word_idx == `IDX_IDLE_LOAD)
			|-> (wb_dat_o[`HALF_W-1:0] == $past(idle_load_status));
	endproperty
	a_idle_read: assert property (p_idle_read)
		else $error("idle load read wrong");

	property p_peak_read;
		(wb_ack_o && !wb_we_i && word_idx == `IDX_PEAK_PHASE)
			|-> (wb_dat_o[`HALF_W-1:0] == $past(peak_phase_status));
	endproperty
	a_peak_read: assert property (p_peak_read)
		else $error("peak phase read wrong");

	property p_ro_write_ignored;
		(wr_commit && (word_idx == `IDX_CAPTURE || word_idx == `IDX_C_FUND_I_RMS))
			|=> $stable(last_word_transfer_capture) && $stable(main_config);
	endproperty
	a_ro_write_ignored: assert property (p_ro_write_ignored)
		else $error("write to read-only word changed state");

	property p_reserved_write_ignored;
		(wr_commit && word_idx >= `IDX_RSVD_HI_FIRST && word_idx <= `IDX_RSVD_HI_LAST)
			|=> $stable(main_config) && $stable(calc_mode_control);
	endproperty
	a_reserved_write_ignored: assert property (p_reserved_write_ignored)
		else $error("reserved write changed a word");

	property p_ack_timing;
		(bus_req && !wb_ack_o && !$past(wb_ack_o)) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_timing: assert property (p_ack_timing)
		else $error("ack not one cycle after request");

	property p_calc_mode_write;
		(wr_commit && word_idx == `IDX_CALC_MODE && wb_sel_i[1:0] == 2'b11)
			|=> (calc_mode_control == $past(wb_dat_i[`HALF_W-1:0]));
	endproperty
	a_calc_mode_write: assert property (p_calc_mode_write)
		else $error("calculation mode write lost");

	property p_pulse_cfg_write;
		(wr_commit && word_idx == `IDX_PULSE_CFG && wb_sel_i[1:0] == 2'b11)
			|=> (pulse_output_config == $past(wb_dat_i[`HALF_W-1:0]));
	endproperty
	a_pulse_cfg_write: assert property (p_pulse_cfg_write)
		else $error("pulse output configuration write lost");

	property p_main_cfg_write;
		(wr_commit && word_idx == `IDX_MAIN_CFG && wb_sel_i[1:0] == 2'b11)
			|=> (main_config == $past(wb_dat_i[`HALF_W-1:0]));
	endproperty
	a_main_cfg_write: assert property (p_main_cfg_write)
		else $error("main configuration write lost");

	property p_word32_write_refused;
		(wr_commit && is_word32)
			|=> $stable(last_word_transfer_capture);
	endproperty
	a_word32_write_refused: assert property (p_word32_write_refused)
		else $error("write to rms word changed the capture");

	property p_reserved_lo_write_ignored;
		(wr_commit && word_idx >= `IDX_RSVD_LO_FIRST && word_idx <= `IDX_RSVD_LO_LAST)
			|=> $stable(main_config) && $stable(line_cycle_count);
	endproperty
	a_reserved_lo_write_ignored: assert property (p_reserved_lo_write_ignored)
		else $error("low reserved write changed a word");

	property p_write_answer_zero;
		(wb_ack_o && wb_we_i)
			|-> (wb_dat_o == `RST_WORD32);
	endproperty
	a_write_answer_zero: assert property (p_write_answer_zero)
		else $error("write answer carried data");

	c_rms_read: cover property (wb_ack_o && !wb_we_i && is_word32);
	c_config_write: cover property (wr_commit && word_idx == `IDX_MAIN_CFG);
	c_reserved_write: cover property (wr_commit && word_idx == `IDX_RSVD_LO_FIRST);
	c_back_to_back: cover property (wb_ack_o ##3 wb_ack_o);

endmodule // metering_config_status_regs

/* verif/tb.sv */
// self-checking wishbone bench for the metering register slice
`timescale 1ns/1ns
`include "metering_regs_consts.svh"

module tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [`BUS_ADR_W-1:0] wb_adr_i = '0;
	logic [`BUS_SEL_W-1:0] wb_sel_i = '0;
	logic [`BUS_DAT_W-1:0] wb_dat_i = '0;
	logic [`BUS_DAT_W-1:0] wb_dat_o;
	logic [`BUS_DAT_W-1:0] last_word_transfer_capture;
	logic wb_ack_o;
	logic [`RMS_W-1:0] phase_c_fund_current_rms = 24'h876543;
	logic [`RMS_W-1:0] phase_c_fund_voltage_rms = 24'h2468ac;
	logic [`HALF_W-1:0] peak_phase_status = 16'h0007;
	logic [`HALF_W-1:0] phase_delay_0 = 16'h1234;
	logic [`HALF_W-1:0] phase_delay_1 = 16'h8765;
	logic [`HALF_W-1:0] phase_delay_2 = 16'hfedc;
	logic [`HALF_W-1:0] idle_load_status = 16'h0155;
	logic [`HALF_W-1:0] power_sign_status = 16'h01aa;
	logic [`HALF_W-1:0] line_cycle_count, crossing_timeout_count, calc_mode_control;
	logic [`HALF_W-1:0] pulse_output_config, pulse1_divisor, pulse2_divisor, pulse3_divisor;
	logic [`HALF_W-1:0] main_config;
	logic [`TRIM_W-1:0] phase_a_phase_trim, phase_b_phase_trim, phase_c_phase_trim;
	int num_errors = 0;
	int compares = 0;
	logic [15:0] rw_idx [0:10] = '{`IDX_LINE_CYCLE, `IDX_CROSS_TOUT, `IDX_CALC_MODE,
		`IDX_PULSE_CFG, `IDX_PULSE1_DIV, `IDX_PULSE2_DIV, `IDX_PULSE3_DIV, `IDX_A_TRIM,
		`IDX_B_TRIM, `IDX_C_TRIM, `IDX_MAIN_CFG};
	logic [15:0] rw_rst [0:10] = '{16'hffff, 16'hffff, 16'h01ff, 16'h0e88, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0010};
	logic [15:0] ro_idx [0:5] = '{`IDX_PEAK_PHASE, `IDX_DELAY_0, `IDX_DELAY_1,
		`IDX_DELAY_2, `IDX_IDLE_LOAD, `IDX_POWER_SIGN};
	logic [15:0] rsvd_idx [0:4] = '{16'he53d, 16'he5fe, 16'he60f, 16'he619, 16'he6ff};
	logic [15:0] port_val [0:10];
	logic [15:0] ro_val [0:5];
	logic [31:0] rd;

	assign port_val = '{line_cycle_count, crossing_timeout_count, calc_mode_control,
		pulse_output_config, pulse1_divisor, pulse2_divisor, pulse3_divisor,
		{6'h00, phase_a_phase_trim}, {6'h00, phase_b_phase_trim},
		{6'h00, phase_c_phase_trim}, main_config};
	assign ro_val = '{peak_phase_status, phase_delay_0, phase_delay_1, phase_delay_2,
		idle_load_status, power_sign_status};

	metering_config_status_regs i_dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .phase_c_fund_current_rms,
		.phase_c_fund_voltage_rms, .peak_phase_status, .phase_delay_0, .phase_delay_1,
		.phase_delay_2, .idle_load_status, .power_sign_status, .line_cycle_count,
		.crossing_timeout_count, .calc_mode_control, .pulse_output_config, .pulse1_divisor,
		.pulse2_divisor, .pulse3_divisor, .phase_a_phase_trim, .phase_b_phase_trim,
		.phase_c_phase_trim, .main_config, .last_word_transfer_capture);

	always #20 core_clk = ~core_clk;

	function automatic logic [15:0] rw_mask(input int i);
		return (i >= 7 && i <= 9) ? 16'h03ff : 16'hffff;
	endfunction

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one classic cycle: hold the request until ack is sampled, then idle one cycle
	task automatic xfer(input logic we, input logic [15:0] idx, input logic [3:0] sel,
		input logic [31:0] wdat, output logic [31:0] rdat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= wdat;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		if (n >= 20)
			check("ack wait", 32'h1, 32'h0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [3:0] sel, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, idx, sel, d, dummy);
	endtask

	task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 4'hf, 32'h0, rd);
		check(name, exp, rd);
	endtask

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic check_resets;
		check("capture after reset", 32'h0, last_word_transfer_capture);
		for (int i = 0; i < 11; i++)
		begin
			rd_chk("reset value", rw_idx[i], {16'h0, rw_rst[i]});
			check("reset port", {16'h0, rw_rst[i]}, {16'h0, port_val[i]});
		end
		$display("test reset values done");
	endtask

	task end_sim;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		repeat (4000) @(posedge core_clk);
		num_errors++;
		end_sim();
	end

	initial
	begin
		logic [15:0] v;
		do_reset();
		check_resets();
		// writable words: upper bus bits must not stick, trims keep ten bits
		for (int i = 0; i < 11; i++)
		begin
			v = (16'hc3a5 + 16'(i) * 16'h0111) & rw_mask(i);
			wr(rw_idx[i], 4'h3, 32'hffff0000 | (16'hc3a5 + 16'(i) * 16'h0111));
			rd_chk("rw readback", rw_idx[i], {16'h0, v});
			check("rw port", {16'h0, v}, {16'h0, port_val[i]});
		end
		wr(`IDX_MAIN_CFG, 4'h3, 32'h00001234);
		wr(`IDX_MAIN_CFG, 4'h1, 32'h0000ffff);
		rd_chk("low lane", `IDX_MAIN_CFG, 32'h000012ff);
		wr(`IDX_MAIN_CFG, 4'h2, 32'h00000000);
		wr(`IDX_MAIN_CFG, 4'hc, 32'hffffffff);
		rd_chk("high lane", `IDX_MAIN_CFG, 32'h000000ff);
		$display("test writable words done");
		// status words follow their inputs and ignore writes
		for (int i = 0; i < 6; i++)
		begin
			wr(ro_idx[i], 4'h3, {16'h0, ~ro_val[i]});
			rd_chk("status word", ro_idx[i], {16'h0, ro_val[i]});
		end
		phase_delay_1 <= 16'h0f0f;
		@(posedge core_clk);
		rd_chk("live delay", `IDX_DELAY_1, 32'h00000f0f);
		$display("test status words done");
		// rms words and the transfer capture
		rd_chk("current rms", `IDX_C_FUND_I_RMS, 32'h00876543);
		check("capture port", 32'h00876543, last_word_transfer_capture);
		rd_chk("capture read", `IDX_CAPTURE, 32'h00876543);
		wr(`IDX_C_FUND_V_RMS, 4'hf, 32'hffffffff);
		wr(`IDX_CAPTURE, 4'hf, 32'h5a5a5a5a);
		rd_chk("capture kept", `IDX_CAPTURE, 32'h00876543);
		rd_chk("voltage rms", `IDX_C_FUND_V_RMS, 32'h002468ac);
		rd_chk("main config", `IDX_MAIN_CFG, 32'h000000ff);
		check("capture new", 32'h002468ac, last_word_transfer_capture);
		$display("test capture done");
		// reserved places accept nothing and read zero
		for (int i = 0; i < 5; i++)
		begin
			wr(rsvd_idx[i], 4'hf, 32'hffffffff);
			rd_chk("reserved", rsvd_idx[i], 32'h0);
		end
		check("config after reserved", 32'h000000ff, {16'h0, main_config});
		$display("test reserved done");
		do_reset();
		check_resets();
		end_sim();
	end
endmodule // tb
